/* rtl/vip_top.sv */
`timescale 1ns/10ps
`default_nettype none
module vip_top #(
  parameter bit HAS_ADC = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Interrupt sources, one-cycle pulses
  input wire vip_pkg::vip_src_t src,
  input wire vip_pkg::vip_trap_t trap,
  input wire vip_pkg::vip_instr_t instr,
  // Core side
  input wire logic core_ack,
  output vip_pkg::vip_core_req_t core_req,
  input wire logic vec_fetch_valid,
  input wire logic [7:0] vec_even_byte,
  input wire logic [7:0] vec_odd_byte,
  output logic [15:0] isr_addr,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import vip_pkg::*;

  // Decoded register: kind 0..2 per group, 3 ctrl, 4 status, 7 unmapped
  typedef struct packed {
    logic [1:0] grp;
    logic [2:0] kind;
  } vip_sel_t;

  function automatic vip_sel_t reg_sel(input logic [7:0] a);
    vip_sel_t s;
    s.grp = 2'h0;
    s.kind = 3'h7;
    for (int g = 0; g < 3; g++) begin
      if (a == VIP_GRP_STRIDE * g[7:0] + VIP_PEND_OFF) begin
        s.grp = g[1:0];
        s.kind = 3'h0;
      end
      if (a == VIP_GRP_STRIDE * g[7:0] + VIP_HI_OFF) begin
        s.grp = g[1:0];
        s.kind = 3'h1;
      end
      if (a == VIP_GRP_STRIDE * g[7:0] + VIP_LO_OFF) begin
        s.grp = g[1:0];
        s.kind = 3'h2;
      end
    end
    if (a == VIP_CTRL_OFF) s.kind = 3'h3;
    if (a == VIP_STAT_OFF) s.kind = 3'h4;
    return s;
  endfunction

  function automatic logic [15:0] vector_of(input logic [4:0] code);
    logic [15:0] v;
    v = 16'h0000;
    case (code)
      VIP_CODE_WDT: v = VIP_VEC_WDT;
      VIP_CODE_POSC: v = VIP_VEC_POSC;
      VIP_CODE_WOSC: v = VIP_VEC_WOSC;
      VIP_CODE_ILL: v = VIP_VEC_ILL;
      default: begin
        if (code >= 5'h10) v = VIP_VEC_G0_LAST - {10'h000, code - 5'h10, 1'b0};
        else if (code >= 5'h08) v = VIP_VEC_G1_LAST - {10'h000, code - 5'h08, 1'b0};
        else v = VIP_VEC_G2_LAST - {10'h000, code, 1'b0};
      end
    endcase
    return v;
  endfunction

  // Converter bit drops out entirely on variants without it
  localparam logic [23:0] PMASK = HAS_ADC ? VIP_PEND_MASK :
                                  VIP_PEND_MASK & ~(24'h000001 << VIP_ADC_BIT);

  logic [23:0] pend_reg;
  logic [23:0] hi_reg;
  logic [23:0] lo_reg;
  logic [3:0] trap_pend_reg;
  logic gie_reg;
  logic wdt_en_reg;
  logic [23:0] src_flat, src_live;
  logic pick_found;
  logic [4:0] pick_idx;
  logic [4:0] win_code;
  logic win_valid;
  logic pend_ack;
  logic [23:0] ack_clr;

  // Shared vectors OR their sources into one pending bit
  assign src_flat = {1'b0, src.timer1, src.timer0, src.uart_rx, src.uart_tx, 2'b00, src.adc,
                     src.pa7 | src.low_voltage_detector,
                     src.pa6 | src.comparator,
                     src.pa_lo[5:4],
                     src.pa_lo[3] | src.pd[3], src.pa_lo[2] | src.pd[2],
                     src.pa_lo[1:0], 4'h0, src.pc};

  // AXI write channel: address and data taken in either order
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic wr_fire;
  vip_sel_t wsel;
  vip_sel_t rsel;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wsel = reg_sel(aw_addr_reg);
  assign rsel = reg_sel(s_axi_araddr);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_strb_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= VIP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wsel.kind == 3'h7) ? VIP_RESP_SLVERR : VIP_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_ok;
  logic [23:0] wr_grp_mask;
  logic [23:0] wr_byte;
  assign wr_ok = wr_fire && w_strb_reg;
  assign wr_grp_mask = 24'h0000ff << (5'd8 * (5'd2 - {3'h0, wsel.grp}));
  assign wr_byte = {w_data_reg, w_data_reg, w_data_reg};

  // Pending bits
  assign pend_ack = core_ack && core_req.req && core_req.code < VIP_CODE_WDT;
  assign ack_clr = pend_ack ? (24'h000001 << core_req.code) : 24'h000000;

  // Incoming pulse wins over both acknowledge and a software clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 24'h000000;
    end else if (wr_ok && wsel.kind == 3'h0) begin
      pend_reg <= (((pend_reg & ~wr_grp_mask) | (wr_byte & wr_grp_mask)) & ~ack_clr
                  | src_flat) & PMASK;
    end else begin
      pend_reg <= ((pend_reg & ~ack_clr) | src_flat) & PMASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_reg <= {3{VIP_RESET_BYTE}};
      lo_reg <= {3{VIP_RESET_BYTE}};
    end else if (wr_ok && wsel.kind == 3'h1) begin
      hi_reg <= (hi_reg & ~wr_grp_mask) | (wr_byte & wr_grp_mask);
    end else if (wr_ok && wsel.kind == 3'h2) begin
      lo_reg <= (lo_reg & ~wr_grp_mask) | (wr_byte & wr_grp_mask);
    end
  end

  // Traps latch until the core takes their vector
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trap_pend_reg <= 4'h0;
    end else begin
      for (int t = 0; t < 4; t++) begin
        if (trap[3-t]) begin
          trap_pend_reg[3-t] <= 1'b1;
        end else if (core_ack && core_req.req && core_req.code == VIP_CODE_WDT + t[4:0]) begin
          trap_pend_reg[3-t] <= 1'b0;
        end
      end
    end
  end

  // Global enable: hardware clears win so a maskable source or the watchdog is never nested
  logic gie_clr;
  logic gie_set;
  logic ctrl_wr;
  assign ctrl_wr = wr_ok && wsel.kind == 3'h3;
  assign gie_clr = (core_ack && core_req.req) || trap.posc_fail || trap.wosc_fail ||
                   trap.illegal || instr.trap_instr || instr.disable_interrupts_instr ||
                   (ctrl_wr && !w_data_reg[VIP_CTRL_GIE_BIT]);
  assign gie_set = instr.enable_interrupts_instr || instr.return_from_interrupt_instr ||
                   (ctrl_wr && w_data_reg[VIP_CTRL_GIE_BIT]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gie_reg <= 1'b0;
    end else if (gie_clr) begin
      gie_reg <= 1'b0;
    end else if (gie_set) begin
      gie_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      wdt_en_reg <= w_data_reg[VIP_CTRL_WDT_BIT];
    end
  end

  vip_prio_pick u_pick (
    .pend(pend_reg),
    .lvl_hi(hi_reg),
    .lvl_lo(lo_reg),
    .found(pick_found),
    .idx(pick_idx)
  );

  // Fixed-rank sources sit above every programmable level
  always_comb begin
    win_valid = 1'b1;
    win_code = VIP_CODE_WDT;
    if (trap_pend_reg[3] && wdt_en_reg && gie_reg) win_code = VIP_CODE_WDT;
    else if (trap_pend_reg[2]) win_code = VIP_CODE_POSC;
    else if (trap_pend_reg[1]) win_code = VIP_CODE_WOSC;
    else if (trap_pend_reg[0]) win_code = VIP_CODE_ILL;
    else if (gie_reg && pick_found) win_code = pick_idx;
    else win_valid = 1'b0;
  end

  // Request drops the cycle after the acknowledge so it is not shown twice
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_req <= '0;
    end else begin
      core_req.req <= win_valid && !core_ack;
      core_req.code <= win_code;
      core_req.vector <= vector_of(win_code);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      isr_addr <= 16'h0000;
    end else if (vec_fetch_valid) begin
      isr_addr <= {vec_even_byte, vec_odd_byte};
    end
  end

  // AXI read channel, answered one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (rsel.kind)
      3'h0: rd_byte = pend_reg[8 * (2 - rsel.grp) +: 8];
      3'h1: rd_byte = hi_reg[8 * (2 - rsel.grp) +: 8];
      3'h2: rd_byte = lo_reg[8 * (2 - rsel.grp) +: 8];
      3'h3: rd_byte = {gie_reg, 6'h00, wdt_en_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= VIP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (rsel.kind == 3'h7) ? VIP_RESP_SLVERR : VIP_RESP_OKAY;
      if (rsel.kind == 3'h4) begin
        s_axi_rdata <= {7'h00, core_req.req, trap_pend_reg, 7'h00, core_req.code,
                        core_req.vector[7:0]};
      end else begin
        s_axi_rdata <= {24'h000000, rd_byte};
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Highest pending level, read only by the checks below
  logic [1:0] max_lvl;
  always_comb begin
    max_lvl = 2'h0;
    for (int b = 0; b < VIP_NSRC; b++) begin
      if (pend_reg[b] && {hi_reg[b], lo_reg[b]} > max_lvl) max_lvl = {hi_reg[b], lo_reg[b]};
    end
  end

  a_level_wins: assert property (@(posedge mclk) disable iff (!rst_n)
    pick_found |-> {hi_reg[pick_idx], lo_reg[pick_idx]} == max_lvl)
    else $error("lower level request won");

  a_ack_clears_gie: assert property (@(posedge mclk) disable iff (!rst_n)
    core_ack && core_req.req |=> !gie_reg && !core_req.req)
    else $error("acknowledge left global enable set");

  a_ei_sets_gie: assert property (@(posedge mclk) disable iff (!rst_n)
    instr.enable_interrupts_instr && !gie_clr |=> gie_reg)
    else $error("enable instruction did not set global enable");

  a_trap_clears_gie: assert property (@(posedge mclk) disable iff (!rst_n)
    instr.trap_instr || trap.illegal |=> !gie_reg)
    else $error("trap left global enable set");

  assign src_live = src_flat & PMASK;
  a_pulse_latched: assert property (@(posedge mclk) disable iff (!rst_n)
    src_live != 24'h000000 |=> (pend_reg & $past(src_live)) == $past(src_live))
    else $error("source pulse lost");

  a_no_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
    (pend_reg & ~PMASK) == 24'h000000)
    else $error("reserved or absent source pending");

  a_gated_forward: assert property (@(posedge mclk) disable iff (!rst_n)
    core_req.req && core_req.code < VIP_CODE_WDT |-> $past(gie_reg))
    else $error("maskable source forwarded while disabled");

  a_timer1_vector: assert property (@(posedge mclk) disable iff (!rst_n)
    core_req.req && core_req.code == 5'h16 |-> core_req.vector == 16'h000a)
    else $error("timer one vector wrong");

  a_trap_rank: assert property (@(posedge mclk) disable iff (!rst_n)
    trap_pend_reg[2] && !(trap_pend_reg[3] && wdt_en_reg && gie_reg) |=>
      core_req.code == VIP_CODE_POSC)
    else $error("oscillator trap outranked");

  c_trap_vectored: cover property (@(posedge mclk) disable iff (!rst_n)
    core_req.req && core_req.code == VIP_CODE_ILL ##1 core_ack);
  c_maskable_vectored: cover property (@(posedge mclk) disable iff (!rst_n)
    core_req.req && core_req.code < VIP_CODE_WDT && core_ack);
  c_set_beats_clear: cover property (@(posedge mclk) disable iff (!rst_n)
    pend_ack && src_flat[core_req.code]);
endmodule
`default_nettype wire

/* rtl/vip_pkg.sv */
package vip_pkg;
  localparam int VIP_NSRC = 24;
  // Flat pending word is {group0, group1, group2}
  localparam logic [23:0] VIP_PEND_MASK = 24'h79ff0f;
  localparam int VIP_ADC_BIT = 16;
  localparam logic [4:0] VIP_CODE_WDT = 5'h18;
  localparam logic [4:0] VIP_CODE_POSC = 5'h19;
  localparam logic [4:0] VIP_CODE_WOSC = 5'h1a;
  localparam logic [4:0] VIP_CODE_ILL = 5'h1b;
  localparam logic [15:0] VIP_VEC_WDT = 16'h0004;
  localparam logic [15:0] VIP_VEC_POSC = 16'h003a;
  localparam logic [15:0] VIP_VEC_WOSC = 16'h003c;
  localparam logic [15:0] VIP_VEC_ILL = 16'h0006;
  localparam logic [15:0] VIP_VEC_G0_LAST = 16'h0016;
  localparam logic [15:0] VIP_VEC_G1_LAST = 16'h0026;
  localparam logic [15:0] VIP_VEC_G2_LAST = 16'h0036;
  localparam logic [1:0] VIP_LVL_TOP = 2'h3;
  // Register byte offsets
  localparam logic [7:0] VIP_GRP_STRIDE = 8'h0c;
  localparam logic [7:0] VIP_PEND_OFF = 8'h00;
  localparam logic [7:0] VIP_HI_OFF = 8'h04;
  localparam logic [7:0] VIP_LO_OFF = 8'h08;
  localparam logic [7:0] VIP_CTRL_OFF = 8'h24;
  localparam logic [7:0] VIP_STAT_OFF = 8'h28;
  localparam int VIP_CTRL_GIE_BIT = 7;
  localparam int VIP_CTRL_WDT_BIT = 0;
  localparam logic [7:0] VIP_RESET_BYTE = 8'h00;
  localparam logic [1:0] VIP_RESP_OKAY = 2'h0;
  localparam logic [1:0] VIP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic timer1;
    logic timer0;
    logic uart_rx;
    logic uart_tx;
    logic adc;
    logic pa7;
    logic low_voltage_detector;
    logic pa6;
    logic comparator;
    logic [5:0] pa_lo;
    logic [3:2] pd;
    logic [3:0] pc;
  } vip_src_t;

  typedef struct packed {
    logic wdt;
    logic posc_fail;
    logic wosc_fail;
    logic illegal;
  } vip_trap_t;

  typedef struct packed {
    logic enable_interrupts_instr;
    logic disable_interrupts_instr;
    logic return_from_interrupt_instr;
    logic trap_instr;
  } vip_instr_t;

  typedef struct packed {
    logic req;
    logic [4:0] code;
    logic [15:0] vector;
  } vip_core_req_t;
endpackage

/* rtl/vip_prio_pick.sv */
`timescale 1ns/10ps
`default_nettype none
module vip_prio_pick (
  // Pending bits and their settings
  input wire logic [vip_pkg::VIP_NSRC-1:0] pend,
  input wire logic [vip_pkg::VIP_NSRC-1:0] lvl_hi,
  input wire logic [vip_pkg::VIP_NSRC-1:0] lvl_lo,
  // Winner
  output logic found,
  output logic [4:0] idx
);
  import vip_pkg::*;

  // Later passes override: higher level, then higher index (earlier vector)
  always_comb begin
    found = 1'b0;
    idx = 5'h00;
    for (int lv = 1; lv <= 3; lv++) begin
      for (int b = 0; b < VIP_NSRC; b++) begin
        if (pend[b] && VIP_PEND_MASK[b] &&
            {lvl_hi[b], lvl_lo[b]} == lv[1:0]) begin
          found = 1'b1;
          idx = b[4:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/vip_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module vip_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Controller side
  input wire vip_pkg::vip_core_req_t core_req,
  output logic core_ack,
  output logic vec_fetch_valid,
  output logic [7:0] vec_even_byte,
  output logic [7:0] vec_odd_byte,
  // Bench side
  input wire logic [3:0] ack_delay,
  output logic [7:0] taken_cnt,
  output logic [15:0] taken_vec
);
  import vip_pkg::*;
  logic [3:0] wait_reg;
  // Arbitrary memory contents, differing between even and odd bytes
  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction
  // Slow core leaves the request standing for ack_delay+1 cycles before it acknowledges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_ack <= 1'b0;
      wait_reg <= 4'h0;
      taken_vec <= 16'h0;
    end else begin
      core_ack <= 1'b0;
      if (core_req.req && !core_ack) begin
        if (wait_reg == ack_delay) begin
          core_ack <= 1'b1;
          taken_vec <= core_req.vector;
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
  // Idle byte lanes toggle so stale data is never mistaken for a fetch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vec_fetch_valid <= 1'b0;
      vec_even_byte <= 8'h00;
      vec_odd_byte <= 8'h00;
      taken_cnt <= 8'h00;
    end else if (core_ack) begin
      vec_fetch_valid <= 1'b1;
      vec_even_byte <= mem_byte(taken_vec);
      vec_odd_byte <= mem_byte(taken_vec | 16'h0001);
      taken_cnt <= taken_cnt + 8'h01;
    end else begin
      vec_fetch_valid <= 1'b0;
      vec_even_byte <= ~vec_even_byte;
      vec_odd_byte <= ~vec_odd_byte;
    end
  end
endmodule
`default_nettype wire

/* tb/vip_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module vip_top_tb;
  import vip_pkg::*;
  localparam logic [15:0] VEC_OF [0:20] = '{16'h0036, 16'h0034, 16'h0032, 16'h0030,
    16'h0022, 16'h0020, 16'h0026, 16'h0024, 16'h0022, 16'h0020, 16'h001e, 16'h001c,
    16'h001a, 16'h001a, 16'h0018, 16'h0018, 16'h0016, 16'h0010, 16'h000e, 16'h000c, 16'h000a};
  localparam logic [7:0] PEND_OK [0:2] = '{8'h79, 8'hff, 8'h0f};
  localparam logic [7:0] CTRL = 8'h24;
  logic mclk, rst_n, core_ack, vec_fetch_valid;
  vip_src_t src;
  vip_trap_t trap;
  vip_instr_t instr;
  vip_core_req_t core_req;
  logic [7:0] vec_even_byte, vec_odd_byte, taken_cnt, takes_seen, s_axi_awaddr, s_axi_araddr;
  logic [15:0] isr_addr, taken_vec;
  logic [3:0] ack_delay, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures, tests_run;

  vip_top i_dut (.mclk, .rst_n, .src, .trap, .instr, .core_ack, .core_req, .vec_fetch_valid,
    .vec_even_byte, .vec_odd_byte, .isr_addr, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  vip_core_model i_core (.mclk, .rst_n, .core_req, .core_ack, .vec_fetch_valid, .vec_even_byte,
    .vec_odd_byte, .ack_delay, .taken_cnt, .taken_vec);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic report_and_stop;
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic hang;
    failures++;
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    last_resp = s_axi_bresp;
    if (n == 64) hang();
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    last_resp = s_axi_rresp;
    if (n == 64) hang();
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_data, exp);
  endtask

  // Sources are single-cycle pulses
  task automatic pulse(input logic [$bits(vip_src_t)-1:0] s, input logic [3:0] t,
      input logic [3:0] i);
    @(posedge mclk);
    src <= vip_src_t'(s);
    trap <= vip_trap_t'(t);
    instr <= vip_instr_t'(i);
    @(posedge mclk);
    src <= '0;
    trap <= '0;
    instr <= '0;
  endtask

  // Waits for the core to take a vector, then checks the fetched address
  task automatic take(input logic [15:0] v);
    int n;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (taken_cnt !== takes_seen) break;
    end
    if (n == 64) hang();
    takes_seen = takes_seen + 8'h01;
    @(posedge mclk);
    chk(32'(taken_vec), 32'(v));
    chk(32'(isr_addr), 32'({v[7:0] ^ 8'h3c, (v[7:0] | 8'h01) ^ 8'h3c}));
  endtask

  initial begin
    rst_n = 1'b0;
    src = '0;
    trap = '0;
    instr = '0;
    ack_delay = 4'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    failures = 0;
    tests_run = 0;
    takes_seen = 8'h00;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(CTRL, 32'h0);
    // Lane zero strobe low leaves the register alone
    s_axi_wstrb <= 4'he;
    wr(CTRL, 32'h80);
    s_axi_wstrb <= 4'hf;
    rchk(CTRL, 32'h0);
    // Reserved pending bits stay clear; software sets and clears the rest
    for (int g = 0; g < 3; g++) begin
      wr(8'(12 * g), 32'hff);
      rchk(8'(12 * g), {24'h0, PEND_OK[g]});
      wr(8'(12 * g), 32'h0);
      rchk(8'(12 * g), 32'h0);
    end
    chk(32'(taken_cnt), 32'h0);
    rchk(8'h2c, 32'h0);
    chk(32'(last_resp), 32'(VIP_RESP_SLVERR));
    // Every maskable source at level one, one at a time
    for (int g = 0; g < 3; g++) begin
      wr(8'(12 * g + 4), 32'h0);
      wr(8'(12 * g + 8), 32'hff);
    end
    wr(CTRL, 32'h80);
    for (int i = 0; i < 21; i++) begin
      pulse(21'h1 << i, 4'h0, 4'h0);
      take(VEC_OF[i]);
      rchk(CTRL, 32'h0);
      pulse(21'h0, 4'h0, 4'b0010);
    end
    for (int g = 0; g < 3; g++) rchk(8'(12 * g), 32'h0);
    rchk(CTRL, 32'h80);
    pulse(21'h0, 4'h0, 4'b0100);
    rchk(CTRL, 32'h0);
    pulse(21'h0, 4'h0, 4'b1000);
    rchk(CTRL, 32'h80);
    pulse(21'h0, 4'h0, 4'b0001);
    rchk(CTRL, 32'h0);
    // Mixed levels: pc0 top, pa4 middle, timer1 and pa5 low, pa3 off
    wr(8'h10, 32'h10);
    wr(8'h14, 32'h20);
    wr(8'h1c, 32'h01);
    wr(8'h20, 32'h01);
    ack_delay <= 4'h3;
    pulse(21'h100e01, 4'h0, 4'h0);
    rchk(8'h0c, 32'h38);
    chk(32'(taken_cnt), 32'(takes_seen));
    pulse(21'h0, 4'h0, 4'b1000);
    take(16'h0036);
    pulse(21'h0, 4'h0, 4'b0010);
    take(16'h001e);
    pulse(21'h0, 4'h0, 4'b0010);
    take(16'h000a);
    pulse(21'h0, 4'h0, 4'b0010);
    take(16'h001c);
    pulse(21'h0, 4'h0, 4'b0010);
    rchk(8'h0c, 32'h08);
    rchk(CTRL, 32'h80);
    chk(32'(taken_cnt), 32'(takes_seen));
    wr(8'h0c, 32'h0);
    // All traps at once, with timer1 at the top maskable level
    wr(8'h04, 32'h40);
    wr(CTRL, 32'h81);
    ack_delay <= 4'h2;
    pulse(21'h100000, 4'hf, 4'h0);
    take(16'h003a);
    take(16'h003c);
    take(16'h0006);
    rchk(CTRL, 32'h01);
    // Watchdog waits for the global enable, then outranks level three timer one
    ack_delay <= 4'hf;
    pulse(21'h0, 4'h0, 4'b0010);
    rchk(8'h28, 32'h01801804);
    take(16'h0004);
    rchk(CTRL, 32'h01);
    pulse(21'h0, 4'h0, 4'b0010);
    take(16'h000a);
    report_and_stop();
  end
endmodule
`default_nettype wire
